// ==== sesc_regs.sv ====
// Exposure thresholds, channel offsets, line/frame sync and pixel clock
`timescale 1ns/1ns
`default_nettype none
module sesc_regs
    import sesc_pkg::*;
#(
    parameter int EXP_W = 8,
    parameter logic [EXP_W-1:0] EXP_RESET = 8'h80,
    parameter logic [EXP_W-1:0] FAST_STEP = 8'h04,
    parameter logic [11:0] LINE_PIXELS = 12'ha28
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire sesc_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic auto_exposure_i,
    input wire logic fast_mode_i,
    input wire logic manual_offset_enable_control_i,
    input wire logic wide_mode_i,
    input wire sesc_ch_avg_t ch_avg_i,
    input wire logic ch_avg_valid_i,
    output logic [EXP_W-1:0] exposure_gain_o,
    output logic [31:0] channel_offsets_o,
    output logic [10:0] line_interval_o,
    output logic [2:0] hwin_end_lsbs_o,
    output logic [2:0] hwin_start_lsbs_o,
    output sesc_sync_t sync_o
);

    // Register storage
    logic [7:0] luma_upper_threshold_r;
    logic [7:0] luma_lower_threshold_r;
    logic [7:0] fast_step_thresholds_r;
    logic [7:0] blue_manual_offset_r;
    logic [7:0] green_blue_row_manual_offset_r;
    logic [7:0] green_red_row_manual_offset_r;
    logic [7:0] line_interval_sync_msbs_r;
    logic [7:0] line_interval_low_r;
    logic [7:0] red_manual_offset_r;
    logic [7:0] frame_sync_extend_low_r;
    logic [7:0] frame_sync_extend_high_r;
    logic [7:0] luma_average_r;
    logic [7:0] luma_average_nxt;
    logic [7:0] line_sync_start_low_r;
    logic [7:0] line_sync_end_low_r;
    logic [7:0] pixclk_divider_hwindow_lsbs_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Write strobes
    wire logic wr_upper = reg_req_i.wr && reg_req_i.addr == OFS_LUMA_UPPER;
    wire logic wr_lower = reg_req_i.wr && reg_req_i.addr == OFS_LUMA_LOWER;
    wire logic wr_fast = reg_req_i.wr && reg_req_i.addr == OFS_FAST_STEP;
    wire logic wr_bofs = reg_req_i.wr && reg_req_i.addr == OFS_BLUE_OFS;
    wire logic wr_gbofs = reg_req_i.wr && reg_req_i.addr == OFS_GB_OFS;
    wire logic wr_grofs = reg_req_i.wr && reg_req_i.addr == OFS_GR_OFS;
    wire logic wr_lmsb = reg_req_i.wr && reg_req_i.addr == OFS_LINE_MSBS;
    wire logic wr_llow = reg_req_i.wr && reg_req_i.addr == OFS_LINE_LOW;
    wire logic wr_rofs = reg_req_i.wr && reg_req_i.addr == OFS_RED_OFS;
    wire logic wr_vsl = reg_req_i.wr && reg_req_i.addr == OFS_VS_EXT_LOW;
    wire logic wr_vsh = reg_req_i.wr && reg_req_i.addr == OFS_VS_EXT_HIGH;
    wire logic wr_avg = reg_req_i.wr && reg_req_i.addr == OFS_LUMA_AVG;
    wire logic wr_hss = reg_req_i.wr && reg_req_i.addr == OFS_HS_START;
    wire logic wr_hse = reg_req_i.wr && reg_req_i.addr == OFS_HS_END;
    wire logic wr_pclk = reg_req_i.wr && reg_req_i.addr == OFS_PIXCLK;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            luma_upper_threshold_r <= RST_LUMA_UPPER;
            luma_lower_threshold_r <= RST_LUMA_LOWER;
            fast_step_thresholds_r <= RST_FAST_STEP;
            blue_manual_offset_r <= RST_CH_OFS;
            green_blue_row_manual_offset_r <= RST_CH_OFS;
            green_red_row_manual_offset_r <= RST_CH_OFS;
            line_interval_sync_msbs_r <= RST_LINE_MSBS;
            line_interval_low_r <= RST_LINE_LOW;
            red_manual_offset_r <= RST_CH_OFS;
            frame_sync_extend_low_r <= RST_VS_EXT;
            frame_sync_extend_high_r <= RST_VS_EXT;
            line_sync_start_low_r <= RST_HS_START;
            line_sync_end_low_r <= RST_HS_END;
            pixclk_divider_hwindow_lsbs_r <= RST_PIXCLK;
        end
        else
        begin
            if (wr_upper) luma_upper_threshold_r <= reg_req_i.wdata;
            if (wr_lower) luma_lower_threshold_r <= reg_req_i.wdata;
            if (wr_fast) fast_step_thresholds_r <= reg_req_i.wdata;
            if (wr_bofs) blue_manual_offset_r <= reg_req_i.wdata;
            if (wr_gbofs) green_blue_row_manual_offset_r <= reg_req_i.wdata;
            if (wr_grofs) green_red_row_manual_offset_r <= reg_req_i.wdata;
            // Bit 7 is stored as written; host keeps it zero
            if (wr_lmsb) line_interval_sync_msbs_r <= reg_req_i.wdata;
            if (wr_llow) line_interval_low_r <= reg_req_i.wdata;
            if (wr_rofs) red_manual_offset_r <= reg_req_i.wdata;
            if (wr_vsl) frame_sync_extend_low_r <= reg_req_i.wdata;
            if (wr_vsh) frame_sync_extend_high_r <= reg_req_i.wdata;
            if (wr_hss) line_sync_start_low_r <= reg_req_i.wdata;
            if (wr_hse) line_sync_end_low_r <= reg_req_i.wdata;
            if (wr_pclk) pixclk_divider_hwindow_lsbs_r <= reg_req_i.wdata;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        case (reg_req_i.addr)
            OFS_LUMA_UPPER: rdata_nxt = luma_upper_threshold_r;
            OFS_LUMA_LOWER: rdata_nxt = luma_lower_threshold_r;
            OFS_FAST_STEP: rdata_nxt = fast_step_thresholds_r;
            OFS_BLUE_OFS: rdata_nxt = blue_manual_offset_r;
            OFS_GB_OFS: rdata_nxt = green_blue_row_manual_offset_r;
            OFS_GR_OFS: rdata_nxt = green_red_row_manual_offset_r;
            OFS_LINE_MSBS: rdata_nxt = line_interval_sync_msbs_r;
            OFS_LINE_LOW: rdata_nxt = line_interval_low_r;
            OFS_RED_OFS: rdata_nxt = red_manual_offset_r;
            OFS_VS_EXT_LOW: rdata_nxt = frame_sync_extend_low_r;
            OFS_VS_EXT_HIGH: rdata_nxt = frame_sync_extend_high_r;
            OFS_LUMA_AVG: rdata_nxt = luma_average_r;
            OFS_HS_START: rdata_nxt = line_sync_start_low_r;
            OFS_HS_END: rdata_nxt = line_sync_end_low_r;
            OFS_PIXCLK: rdata_nxt = pixclk_divider_hwindow_lsbs_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_r <= 8'h00;
        else if (reg_req_i.rd)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata_o = rdata_r;

    // Luminance average from the four channel averages
    logic [9:0] ch_sum;
    logic [7:0] luma_calc;
    sesc_ae_state_t ae_state_r;
    sesc_ae_state_t ae_state_nxt;

    assign ch_sum = 10'(ch_avg_i.b) + 10'(ch_avg_i.gb)
                  + 10'(ch_avg_i.gr) + 10'(ch_avg_i.r);
    assign luma_calc = ch_sum[LUMA_SHIFT+7:LUMA_SHIFT];

    // A measured value landing with a host write wins over the write
    wire logic avg_load = ae_state_r == AE_IDLE && ch_avg_valid_i;
    assign luma_average_nxt = avg_load ? luma_calc
                            : wr_avg ? reg_req_i.wdata
                            : luma_average_r;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            luma_average_r <= RST_LUMA_AVG;
        else
            luma_average_r <= luma_average_nxt;
    end

    // Auto exposure and gain loop, one step per measured frame
    logic [EXP_W-1:0] exp_r;
    logic [EXP_W-1:0] exp_nxt;
    logic [EXP_W-1:0] step;
    logic [EXP_W:0] exp_up;
    logic [EXP_W:0] exp_dn;

    wire logic luma_high = luma_average_r > luma_upper_threshold_r;
    wire logic luma_low = luma_average_r < luma_lower_threshold_r;
    wire logic [3:0] luma_nib = luma_average_r[7:4];
    wire logic fast_far = fast_mode_i
        && (luma_nib > fast_step_thresholds_r[FAST_HI_MSB:FAST_HI_LSB]
        || luma_nib < fast_step_thresholds_r[FAST_LO_MSB:FAST_LO_LSB]);

    assign step = fast_far ? FAST_STEP : EXP_W'(1);
    assign exp_up = {1'b0, exp_r} + {1'b0, step};
    assign exp_dn = {1'b0, exp_r} - {1'b0, step};

    always_comb
    begin
        ae_state_nxt = ae_state_r;
        exp_nxt = exp_r;
        case (ae_state_r)
            AE_IDLE:
                if (ch_avg_valid_i)
                    ae_state_nxt = AE_CALC;
            AE_CALC:
                ae_state_nxt = auto_exposure_i ? AE_STEP : AE_IDLE;
            AE_STEP:
            begin
                ae_state_nxt = AE_IDLE;
                // Saturate rather than wrap, so a bright scene never
                // flips to full exposure
                if (luma_high)
                    exp_nxt = exp_dn[EXP_W] ? '0 : exp_dn[EXP_W-1:0];
                else if (luma_low)
                    exp_nxt = exp_up[EXP_W] ? '1 : exp_up[EXP_W-1:0];
                else
                    exp_nxt = exp_r;
            end
            default:
                ae_state_nxt = AE_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ae_state_r <= AE_IDLE;
            exp_r <= EXP_RESET;
        end
        else
        begin
            ae_state_r <= ae_state_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign exposure_gain_o = exp_r;

    // Manual channel offsets: blue, green-blue, green-red, red
    logic [7:0] ofs_setting [4];
    assign ofs_setting[0] = blue_manual_offset_r;
    assign ofs_setting[1] = green_blue_row_manual_offset_r;
    assign ofs_setting[2] = green_red_row_manual_offset_r;
    assign ofs_setting[3] = red_manual_offset_r;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_ofs
            sesc_offset u_ofs (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .enable_i(manual_offset_enable_control_i),
                .setting_i(ofs_setting[ch]),
                .offset_o(channel_offsets_o[ch*8 +: 8])
            );
        end
    endgenerate

    // Line interval and sync positions
    wire logic [10:0] line_interval = {
        line_interval_sync_msbs_r[LINE_MSB_HI:LINE_MSB_LO],
        line_interval_low_r};
    wire logic [9:0] hs_start = {
        line_interval_sync_msbs_r[HS_START_HI:HS_START_LO],
        line_sync_start_low_r};
    wire logic [9:0] hs_end = {
        line_interval_sync_msbs_r[HS_END_HI:HS_END_LO],
        line_sync_end_low_r};
    wire logic [11:0] hs_start_pix = 12'(hs_start) << SYNC_POS_SHIFT;
    wire logic [11:0] hs_end_pix = 12'(hs_end) << SYNC_POS_SHIFT;

    // Each interval count adds one line, so the frame stretches by one
    // part in the base line count of the mode
    wire logic [15:0] base_lines = wide_mode_i ? FRAME_LINES_WIDE
                                               : FRAME_LINES_NARROW;
    wire logic [16:0] frame_lines = 17'(base_lines)
                                  + 17'(line_interval);
    wire logic [16:0] vs_ext = {1'b0, frame_sync_extend_high_r,
                                frame_sync_extend_low_r};
    wire logic [16:0] vs_lines = VS_BASE_LINES + vs_ext;

    logic [11:0] h_cnt_r;
    logic [16:0] v_cnt_r;
    logic hsync_r;
    logic vsync_r;
    wire logic line_end = h_cnt_r == LINE_PIXELS - 12'h001;
    wire logic frame_end = v_cnt_r >= frame_lines - 17'h00001;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            h_cnt_r <= 12'h000;
            v_cnt_r <= 17'h00000;
            hsync_r <= 1'b0;
            vsync_r <= 1'b0;
        end
        else
        begin
            h_cnt_r <= line_end ? 12'h000 : h_cnt_r + 12'h001;
            if (line_end)
                v_cnt_r <= frame_end ? 17'h00000 : v_cnt_r + 17'h00001;
            hsync_r <= h_cnt_r >= hs_start_pix
                    && h_cnt_r < hs_end_pix;
            // Extension past the frame length simply holds sync high
            vsync_r <= v_cnt_r < vs_lines;
        end
    end

    // Pixel clock divider as a tick, keeping the design on one clock
    logic [1:0] div_cnt_r;
    logic tick_r;
    wire logic [1:0] pclk_sel = pixclk_divider_hwindow_lsbs_r[
        PCLK_SEL_HI:PCLK_SEL_LO];
    wire logic [1:0] div_mask = pclk_sel == PCLK_DIV4 ? 2'b11
                              : pclk_sel == PCLK_DIV2 ? 2'b01
                              : 2'b00;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_cnt_r <= 2'b00;
            tick_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 2'b01;
            tick_r <= (div_cnt_r & div_mask) == 2'b00;
        end
    end

    assign sync_o.hsync = hsync_r;
    assign sync_o.vsync = vsync_r;
    assign sync_o.pixel_tick = tick_r;
    assign line_interval_o = line_interval;
    assign hwin_end_lsbs_o = pixclk_divider_hwindow_lsbs_r[
        HWIN_END_HI:HWIN_END_LO];
    assign hwin_start_lsbs_o = pixclk_divider_hwindow_lsbs_r[
        HWIN_START_HI:HWIN_START_LO];

endmodule
`default_nettype wire

// ==== sesc_pkg.sv ====
// Constants and carrier types for the exposure, offset and sync registers
package sesc_pkg;

    // Register offsets on the control port
    localparam logic [7:0] OFS_LUMA_UPPER = 8'h24;
    localparam logic [7:0] OFS_LUMA_LOWER = 8'h25;
    localparam logic [7:0] OFS_FAST_STEP = 8'h26;
    localparam logic [7:0] OFS_BLUE_OFS = 8'h27;
    localparam logic [7:0] OFS_GB_OFS = 8'h28;
    localparam logic [7:0] OFS_GR_OFS = 8'h29;
    localparam logic [7:0] OFS_LINE_MSBS = 8'h2a;
    localparam logic [7:0] OFS_LINE_LOW = 8'h2b;
    localparam logic [7:0] OFS_RED_OFS = 8'h2c;
    localparam logic [7:0] OFS_VS_EXT_LOW = 8'h2d;
    localparam logic [7:0] OFS_VS_EXT_HIGH = 8'h2e;
    localparam logic [7:0] OFS_LUMA_AVG = 8'h2f;
    localparam logic [7:0] OFS_HS_START = 8'h30;
    localparam logic [7:0] OFS_HS_END = 8'h31;
    localparam logic [7:0] OFS_PIXCLK = 8'h32;

    // Reset values
    localparam logic [7:0] RST_LUMA_UPPER = 8'h78;
    localparam logic [7:0] RST_LUMA_LOWER = 8'h68;
    localparam logic [7:0] RST_FAST_STEP = 8'hd4;
    localparam logic [7:0] RST_CH_OFS = 8'h80;
    localparam logic [7:0] RST_LINE_MSBS = 8'h00;
    localparam logic [7:0] RST_LINE_LOW = 8'h00;
    localparam logic [7:0] RST_VS_EXT = 8'h00;
    localparam logic [7:0] RST_LUMA_AVG = 8'h00;
    localparam logic [7:0] RST_HS_START = 8'h08;
    localparam logic [7:0] RST_HS_END = 8'h30;
    localparam logic [7:0] RST_PIXCLK = 8'h36;

    // Field positions
    localparam int FAST_HI_MSB = 7;
    localparam int FAST_HI_LSB = 4;
    localparam int FAST_LO_MSB = 3;
    localparam int FAST_LO_LSB = 0;
    localparam int OFS_DIR_BIT = 7;
    localparam int LINE_MSB_HI = 6;
    localparam int LINE_MSB_LO = 4;
    localparam int HS_END_HI = 3;
    localparam int HS_END_LO = 2;
    localparam int HS_START_HI = 1;
    localparam int HS_START_LO = 0;
    localparam int PCLK_SEL_HI = 7;
    localparam int PCLK_SEL_LO = 6;
    localparam int HWIN_END_HI = 5;
    localparam int HWIN_END_LO = 3;
    localparam int HWIN_START_HI = 2;
    localparam int HWIN_START_LO = 0;

    // Timing counts
    localparam logic [16:0] VS_BASE_LINES = 17'h00004;
    localparam int VS_HIGH_SHIFT = 8;
    localparam int SYNC_POS_SHIFT = 1;
    localparam logic [15:0] FRAME_LINES_WIDE = 16'h0910;
    localparam logic [15:0] FRAME_LINES_NARROW = 16'h0600;
    localparam int LUMA_SHIFT = 2;

    // Pixel clock divide selections
    localparam logic [1:0] PCLK_DIV2 = 2'b10;
    localparam logic [1:0] PCLK_DIV4 = 2'b11;

    // Auto loop states, Gray along idle, calc, step
    typedef enum logic [1:0] {
        AE_IDLE = 2'b00,
        AE_CALC = 2'b01,
        AE_STEP = 2'b11
    } sesc_ae_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sesc_reg_req_t;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] gb;
        logic [7:0] gr;
        logic [7:0] r;
    } sesc_ch_avg_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic pixel_tick;
    } sesc_sync_t;

endpackage

// ==== sesc_offset.sv ====
// Sign-magnitude channel offset to two's complement, gated by enable
`timescale 1ns/1ns
`default_nettype none
module sesc_offset
    import sesc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic [7:0] setting_i,
    output logic signed [7:0] offset_o
);

    logic [7:0] mag_ext;
    logic signed [7:0] applied;
    logic signed [7:0] offset_r;

    assign mag_ext = {1'b0, setting_i[OFS_DIR_BIT-1:0]};
    // Direction bit picks add or subtract of the magnitude
    assign applied = setting_i[OFS_DIR_BIT] ? -$signed(mag_ext)
                                            : $signed(mag_ext);

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            offset_r <= 8'sh00;
        else
            offset_r <= enable_i ? applied : 8'sh00;
    end

    assign offset_o = offset_r;

endmodule
`default_nettype wire

// ==== sesc_regs_monitor.sv ====
// Port checker for the exposure, offset and sync register block
`timescale 1ns/1ns
`default_nettype none
module sesc_regs_monitor
    import sesc_pkg::*;
#(
    parameter int EXP_W = 8
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire sesc_reg_req_t reg_req_i,
    input wire logic auto_exposure_i,
    input wire logic manual_offset_enable_control_i,
    input wire logic ch_avg_valid_i,
    input wire logic [EXP_W-1:0] exposure_gain_o,
    input wire logic [31:0] channel_offsets_o,
    input wire logic [10:0] line_interval_o,
    input wire logic [2:0] hwin_end_lsbs_o,
    input wire logic [2:0] hwin_start_lsbs_o,
    input wire sesc_sync_t sync_o
);
    logic [1:0] sel_r;
    wire logic wr_pclk = reg_req_i.wr && reg_req_i.addr == OFS_PIXCLK;
    wire logic wr_blue = reg_req_i.wr && reg_req_i.addr == OFS_BLUE_OFS;
    wire logic en = manual_offset_enable_control_i;
    wire logic tick = sync_o.pixel_tick;
    wire logic [7:0] mag = {1'b0, reg_req_i.wdata[6:0]};
    // Shadow of the divider select; tick phase is free after a change
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sel_r <= RST_PIXCLK[7:6];
        else if (wr_pclk)
            sel_r <= reg_req_i.wdata[7:6];
    end
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    a_offsets_zero_off: assert property (
        !en |=> channel_offsets_o == 32'h0)
        else $error("Offsets not zero while disabled");
    a_offset_sign_mag: assert property (
        wr_blue && en ##1 en && !wr_blue |=> channel_offsets_o[7:0] ==
        ($past(reg_req_i.wdata[7], 2) ? 8'h00 - $past(mag, 2) : $past(mag, 2)))
        else $error("Blue offset sign or magnitude wrong");
    a_line_low_byte: assert property (
        reg_req_i.wr && reg_req_i.addr == OFS_LINE_LOW |=>
        line_interval_o[7:0] == $past(reg_req_i.wdata))
        else $error("Line interval low byte not taken");
    a_line_top_bits: assert property (
        reg_req_i.wr && reg_req_i.addr == OFS_LINE_MSBS |=>
        line_interval_o[10:8] == $past(reg_req_i.wdata[6:4]))
        else $error("Line interval top bits not taken");
    a_hwin_lsbs_held: assert property (
        wr_pclk |=>
        {hwin_end_lsbs_o, hwin_start_lsbs_o} == $past(reg_req_i.wdata[5:0]))
        else $error("Window lsbs not taken");
    a_tick_div_four: assert property (
        (sel_r == 2'b11) [*4] ##0 tick ##1 (sel_r == 2'b11) [*3] |->
        !tick && !$past(tick) && !$past(tick, 2))
        else $error("Divide by four tick too early");
    a_tick_undivided: assert property (
        (sel_r == 2'b00) [*3] |-> tick)
        else $error("Undivided tick missing");
    a_exp_after_avg: assert property (
        $changed(exposure_gain_o) |->
        $past(ch_avg_valid_i, 3) || $past(ch_avg_valid_i, 4))
        else $error("Exposure moved without a new average");
    a_exp_held_manual: assert property (
        !auto_exposure_i [*5] |-> $stable(exposure_gain_o))
        else $error("Exposure moved with auto loop off");
endmodule
bind sesc_regs sesc_regs_monitor #(.EXP_W(EXP_W)) u_monitor (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .auto_exposure_i(auto_exposure_i), .ch_avg_valid_i(ch_avg_valid_i),
    .manual_offset_enable_control_i(manual_offset_enable_control_i),
    .exposure_gain_o(exposure_gain_o), .channel_offsets_o(channel_offsets_o),
    .line_interval_o(line_interval_o), .hwin_end_lsbs_o(hwin_end_lsbs_o),
    .hwin_start_lsbs_o(hwin_start_lsbs_o), .sync_o(sync_o));
`default_nettype wire

// ==== sesc_host_model.sv ====
// Host processor model driving the register port
`timescale 1ns/1ns
`default_nettype none
module sesc_host_model
    import sesc_pkg::*;
(
    input wire logic clock_i,
    output var sesc_reg_req_t reg_req_o,
    input wire logic [7:0] reg_rdata_i
);
    initial
    begin
        reg_req_o = '0;
    end
    // Address is scrambled when idle so a stale value is never relied on
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_req_o.addr = a;
        reg_req_o.wdata = (a == OFS_LINE_MSBS) ? (d & 8'h7f) : d;
        reg_req_o.wr = 1'b1;
        @(posedge clock_i);
        #1;
        reg_req_o.wr = 1'b0;
        reg_req_o.addr = ~a;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_req_o.addr = a;
        reg_req_o.rd = 1'b1;
        @(posedge clock_i);
        #1;
        reg_req_o.rd = 1'b0;
        reg_req_o.addr = ~a;
        @(posedge clock_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== sesc_regs_test.sv ====
// Self-checking bench for the exposure, offset and sync register block
`timescale 1ns/1ns
`default_nettype none
module sesc_regs_test
    import sesc_pkg::*;
;
    localparam logic [7:0] RST_TAB [15] = '{8'h78, 8'h68, 8'hd4, 8'h80,
        8'h80, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h08,
        8'h30, 8'h36};
    localparam int TICKS [4] = '{16, 16, 8, 4};
    int n_errors = 0;
    int cmp_count = 0;
    int k;
    int hi;
    int lo;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic auto_exp = 1'b0;
    logic fast = 1'b0;
    logic wide = 1'b0;
    logic ofs_en = 1'b0;
    logic avg_valid = 1'b0;
    sesc_ch_avg_t ch_avg = '0;
    sesc_reg_req_t req;
    logic [7:0] rdata;
    logic [7:0] rd_val;
    logic [7:0] exp_gain;
    logic [31:0] offsets;
    logic [10:0] line_iv;
    logic [2:0] hw_end;
    logic [2:0] hw_start;
    sesc_sync_t sync;
    initial
    begin
        forever #4 clock_i = ~clock_i;
    end
    sesc_host_model host (.clock_i(clock_i), .reg_req_o(req),
        .reg_rdata_i(rdata));
    // Short lines keep a narrow frame near twelve thousand cycles, a wide one under twenty thousand
    sesc_regs #(.LINE_PIXELS(12'd8)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .auto_exposure_i(auto_exp),
        .fast_mode_i(fast), .manual_offset_enable_control_i(ofs_en),
        .wide_mode_i(wide), .ch_avg_i(ch_avg), .ch_avg_valid_i(avg_valid),
        .exposure_gain_o(exp_gain), .channel_offsets_o(offsets),
        .line_interval_o(line_iv), .hwin_end_lsbs_o(hw_end),
        .hwin_start_lsbs_o(hw_start), .sync_o(sync));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic do_reset();
        rst_n_i = 1'b0;
        cycles(2);
        rst_n_i = 1'b1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        host.read_reg(a, rd_val);
        check(rd_val, want);
    endtask
    task automatic send_avg(input logic [31:0] ch, input logic [7:0] avg,
        input logic [7:0] want);
        ch_avg = sesc_ch_avg_t'(ch);
        avg_valid = 1'b1;
        cycles(1);
        avg_valid = 1'b0;
        cycles(5);
        check(exp_gain, want);
        rd_chk(OFS_LUMA_AVG, avg);
    endtask
    task automatic count_bit(input int which, input int n, output int cnt);
        cnt = 0;
        repeat (n)
        begin
            cycles(1);
            if (sync[which] === 1'b1)
                cnt++;
        end
    endtask
    task automatic wait_vs(input logic lvl, output int cnt);
        cnt = 0;
        while (sync.vsync !== lvl && cnt < 20000)
        begin
            cycles(1);
            cnt++;
        end
        if (cnt == 20000)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, cnt, lvl);
            give_verdict();
        end
    endtask
    initial
    begin
        do_reset();
        for (int i = 0; i < 15; i++)
            rd_chk(8'h24 + 8'(i), RST_TAB[i]);
        rd_chk(8'h23, 8'h00);
        rd_chk(8'h33, 8'h00);
        for (int i = 0; i < 15; i++)
            host.write_reg(8'h24 + 8'(i), 8'(i * 11 + 1));
        for (int i = 0; i < 15; i++)
            rd_chk(8'h24 + 8'(i), 8'(i * 11 + 1));
        $display("Register test done");
        do_reset();
        auto_exp = 1'b1;
        send_avg(32'ha0a0a0a3, 8'ha0, 8'h7f);
        send_avg(32'h10203041, 8'h28, 8'h80);
        send_avg(32'h78787878, 8'h78, 8'h80);
        send_avg(32'h68686868, 8'h68, 8'h80);
        fast = 1'b1;
        send_avg(32'hf0f0f0f0, 8'hf0, 8'h7c);
        send_avg(32'ha0a0a0a0, 8'ha0, 8'h7b);
        send_avg(32'h20202020, 8'h20, 8'h7f);
        auto_exp = 1'b0;
        send_avg(32'h10101010, 8'h10, 8'h7f);
        $display("Auto loop test done");
        host.write_reg(OFS_BLUE_OFS, 8'h85);
        host.write_reg(OFS_GB_OFS, 8'h05);
        host.write_reg(OFS_GR_OFS, 8'h00);
        host.write_reg(OFS_RED_OFS, 8'hff);
        cycles(2);
        check(offsets, 32'h0);
        ofs_en = 1'b1;
        cycles(2);
        check(offsets, 32'h810005fb);
        host.write_reg(OFS_BLUE_OFS, 8'h7f);
        cycles(2);
        check(offsets, 32'h8100057f);
        $display("Offset test done");
        for (int s = 0; s < 4; s++)
        begin
            host.write_reg(OFS_PIXCLK, {2'(s), 6'h3c});
            cycles(6);
            check({hw_end, hw_start}, 32'h3c);
            count_bit(0, 16, k);
            check(k, TICKS[s]);
        end
        host.write_reg(OFS_HS_START, 8'h01);
        host.write_reg(OFS_HS_END, 8'h03);
        cycles(4);
        count_bit(2, 64, k);
        check(k, 32);
        host.write_reg(OFS_LINE_MSBS, 8'h04);
        cycles(4);
        count_bit(2, 64, k);
        check(k, 48);
        host.write_reg(OFS_LINE_LOW, 8'h10);
        wait_vs(1'b0, k);
        wait_vs(1'b1, k);
        wait_vs(1'b0, hi);
        wait_vs(1'b1, lo);
        check(hi, 32);
        check(hi + lo, (1536 + 16) * 8);
        host.write_reg(OFS_VS_EXT_LOW, 8'h02);
        host.write_reg(OFS_VS_EXT_HIGH, 8'h01);
        wait_vs(1'b0, k);
        wait_vs(1'b1, k);
        wait_vs(1'b0, hi);
        check(hi, (4 + 256 + 2) * 8);
        // Wide base takes effect within the frame now running
        wide = 1'b1;
        wait_vs(1'b1, k);
        wait_vs(1'b0, hi);
        wait_vs(1'b1, lo);
        check(hi + lo, (2320 + 16) * 8);
        $display("Sync test done");
        host.write_reg(OFS_LINE_MSBS, 8'he0);
        host.write_reg(OFS_LINE_LOW, 8'hf1);
        check(line_iv, 32'd1777);
        rd_chk(OFS_LINE_MSBS, 8'h60);
        $display("Line interval test done");
        give_verdict();
    end
endmodule
`default_nettype wire
